// *** reset_cause_pkg.sv ***
// Constants, register map and state codes for the reset cause and start-up sequencer
package reset_cause_pkg;

    // System clock rate
    localparam int SYS_CLK_MHZ = 125;

    // Register byte offsets on the AXI4-Lite port
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CPU_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;

    // Field positions
    localparam int BIT_BROWNOUT = 0;
    localparam int BIT_POWERON = 1;
    localparam int BIT_SLEEP_ENTERED = 3;
    localparam int BIT_WATCHDOG_EXPIRED = 4;

    // Event bits of the interrupt status and mask registers
    localparam int EV_W = 6;
    localparam int EV_POWERON = 0;
    localparam int EV_BROWNOUT = 1;
    localparam int EV_EXT_PIN = 2;
    localparam int EV_WDT_RESET = 3;
    localparam int EV_WDT_WAKE = 4;
    localparam int EV_IRQ_WAKE = 5;
    localparam logic [EV_W-1:0] IRQ_STATUS_RESET = 6'h01;
    localparam logic [EV_W-1:0] IRQ_MASK_RESET = 6'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Program counter values
    localparam int PC_W = 13;
    localparam logic [PC_W-1:0] PC_RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] PC_IRQ_VECTOR = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

    // Timing: start-up timer length is not fixed here, a plain default
    localparam int STARTUP_TIMER_US = 64;
    localparam int STARTUP_TIMER_CYCLES = STARTUP_TIMER_US * SYS_CLK_MHZ;
    // Processor start-up delay, least of 5 us, rounded up to whole cycles
    localparam int CPU_DELAY_NS = 5000;
    localparam int CPU_DELAY_CYCLES = (CPU_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
    // Crystal settling count in oscillator cycles
    localparam int CRYSTAL_SETTLE_TICKS = 1024;

    // Oscillator configuration codes
    localparam logic [1:0] OSC_CRYSTAL = 2'h0;
    localparam logic [1:0] OSC_RC = 2'h1;
    localparam logic [1:0] OSC_SECONDARY = 2'h2;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        S_RUN = 5'b00001,
        S_PIN_HOLD = 5'b00010,
        S_TIMER = 5'b00100,
        S_SETTLE = 5'b01000,
        S_CPU_DELAY = 5'b10000
    } seq_state_t;

endpackage : reset_cause_pkg

// *** reset_cause_status_logic.sv ***
// Reset cause flags, processor status flags and start-up sequencer with AXI4-Lite registers
// Operation
// - Bit 0 brownout flag, cleared by brown-out
// - Brownout flag meaningless while detection disabled
// - Bit 1 poweron flag, cleared only by power-on
// - Start-up timer runs first at power-on
// - Crystal modes count 1024 oscillator cycles
// - Processor delay on wake, and on power-on, brown-out with timer disabled; non-crystal modes only
// - Power-on sets both status flags, clears poweron
// - Cause encodings for brown-out and watchdog
// - Pin reset while running keeps status flags
// - Pin reset in sleep, irq wake: 1,0
// - Resets load 000h, wakes resume next
// - Irq wake with global enable vectors 0004h
// - Status register values per cause
// - Cause bits change only on power/brown-out
// - Register init scope differs by cause
//
// Local design decisions: the address map and register access over AXI4-Lite.
module reset_cause_status_logic
    import reset_cause_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = STARTUP_TIMER_CYCLES,
    parameter logic BROWNOUT_POR_VALUE = 1'b0
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_bor_enable,
    input wire logic i_bor_detect,
    input wire logic i_ext_reset_n,
    input wire logic i_watchdog_timeout,
    input wire logic i_watchdog_clear,
    input wire logic i_sleep_enter,
    input wire logic i_irq_wake,
    input wire logic i_global_irq_enable,
    input wire logic i_startup_timer_disable,
    input wire logic [1:0] i_osc_mode,
    input wire logic i_osc_tick,
    input wire logic [PC_W-1:0] i_pc_current,
    output logic o_cpu_hold,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_ctrl_init,
    output logic o_data_init,
    output logic o_watchdog_expired_flag,
    output logic o_sleep_entered_flag,
    output logic o_irq
);

    localparam int CNT_MAX = (STARTUP_CYCLES > CPU_DELAY_CYCLES) ? STARTUP_CYCLES
                                                                 : CPU_DELAY_CYCLES;
    localparam int CNT_W = $clog2(CNT_MAX + CRYSTAL_SETTLE_TICKS) + 1;
    localparam logic [CNT_W-1:0] TIMER_LAST = CNT_W'(STARTUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(CRYSTAL_SETTLE_TICKS - 1);
    localparam logic [CNT_W-1:0] CPU_LAST = CNT_W'(CPU_DELAY_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // Bus slave state
    logic aw_held, next_aw_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic wr_fire;

    // Cause and sequencer state
    seq_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic brownout_flag, next_brownout_flag;
    logic poweron_flag, next_poweron_flag;
    logic watchdog_expired_flag, next_watchdog_expired_flag;
    logic sleep_entered_flag, next_sleep_entered_flag;
    logic sleeping, next_sleeping;
    logic pc_load, next_pc_load;
    logic [PC_W-1:0] pc_value, next_pc_value;
    logic ctrl_init, next_ctrl_init;
    logic data_init, next_data_init;
    logic [EV_W-1:0] irq_status, next_irq_status;
    logic [EV_W-1:0] irq_mask, next_irq_mask;
    logic [EV_W-1:0] events;
    seq_state_t wake_state;
    logic [PC_W-1:0] pc_next_instr;

    assign wr_fire = aw_held && w_held && !bvalid;
    assign o_awready = !aw_held && !bvalid;
    assign o_wready = !w_held && !bvalid;
    assign o_arready = !rvalid;
    assign o_bvalid = bvalid;
    assign o_bresp = bresp;
    assign o_rvalid = rvalid;
    assign o_rdata = rdata;
    assign o_rresp = rresp;

    // Bus channels: address and data may arrive in either order
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (i_awvalid && o_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            next_w_held = 1'b1;
            next_w_data = i_wdata;
            next_w_strb = i_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            unique case (aw_addr)
                OFS_RESET_CAUSE_FLAGS, OFS_CPU_STATUS, OFS_IRQ_STATUS,
                OFS_IRQ_MASK: next_bresp = RESP_OKAY;
                default: next_bresp = RESP_SLVERR;
            endcase
        end else if (bvalid && i_bready) begin
            next_bvalid = 1'b0;
        end
        if (i_arvalid && o_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (i_araddr)
                OFS_RESET_CAUSE_FLAGS: begin
                    next_rdata[BIT_BROWNOUT] = brownout_flag;
                    next_rdata[BIT_POWERON] = poweron_flag;
                end
                OFS_CPU_STATUS: begin
                    next_rdata[BIT_WATCHDOG_EXPIRED] = watchdog_expired_flag;
                    next_rdata[BIT_SLEEP_ENTERED] = sleep_entered_flag;
                end
                OFS_IRQ_STATUS: next_rdata[EV_W-1:0] = irq_status;
                OFS_IRQ_MASK: next_rdata[EV_W-1:0] = irq_mask;
                default: next_rresp = RESP_SLVERR;
            endcase
        end else if (rvalid && i_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // Wake-up delay depends on the oscillator: crystals must settle first
    assign wake_state = (i_osc_mode == OSC_CRYSTAL) ? S_SETTLE : S_CPU_DELAY;
    assign pc_next_instr = i_pc_current + PC_STEP;

    // Cause capture and start-up sequencing; later causes override earlier ones
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_brownout_flag = brownout_flag;
        next_poweron_flag = poweron_flag;
        next_watchdog_expired_flag = watchdog_expired_flag;
        next_sleep_entered_flag = sleep_entered_flag;
        next_sleeping = sleeping;
        next_pc_load = 1'b0;
        next_pc_value = pc_value;
        next_ctrl_init = ctrl_init;
        next_data_init = data_init;
        events = '0;
        // Software side: only the two cause bits hold state
        if (wr_fire && aw_addr == OFS_RESET_CAUSE_FLAGS && w_strb[0]) begin
            next_brownout_flag = w_data[BIT_BROWNOUT];
            next_poweron_flag = w_data[BIT_POWERON];
        end
        unique case (state)
            S_RUN: begin
                if (i_watchdog_timeout && sleeping) begin
                    next_watchdog_expired_flag = 1'b0;
                    next_sleep_entered_flag = 1'b0;
                    next_sleeping = 1'b0;
                    next_pc_value = pc_next_instr;
                    next_cnt = '0;
                    next_state = wake_state;
                    events[EV_WDT_WAKE] = 1'b1;
                end else if (i_watchdog_timeout) begin
                    next_watchdog_expired_flag = 1'b0;
                    next_sleep_entered_flag = 1'b1;
                    next_pc_value = PC_RESET_VECTOR;
                    next_ctrl_init = 1'b1;
                    next_state = S_PIN_HOLD;
                    events[EV_WDT_RESET] = 1'b1;
                end else if (i_irq_wake && sleeping) begin
                    next_watchdog_expired_flag = 1'b1;
                    next_sleep_entered_flag = 1'b0;
                    next_sleeping = 1'b0;
                    next_pc_value = i_global_irq_enable ? PC_IRQ_VECTOR
                                                        : pc_next_instr;
                    next_cnt = '0;
                    next_state = wake_state;
                    events[EV_IRQ_WAKE] = 1'b1;
                end else if (i_sleep_enter) begin
                    next_sleeping = 1'b1;
                    next_watchdog_expired_flag = 1'b1;
                    next_sleep_entered_flag = 1'b0;
                end else if (i_watchdog_clear) begin
                    next_watchdog_expired_flag = 1'b1;
                    next_sleep_entered_flag = 1'b1;
                end
            end
            S_TIMER: begin
                // Disabled timer is skipped at once
                if (i_startup_timer_disable || cnt == TIMER_LAST) begin
                    next_cnt = '0;
                    next_state = (i_osc_mode == OSC_CRYSTAL) ? S_SETTLE
                        : (i_startup_timer_disable ? S_CPU_DELAY : S_PIN_HOLD);
                end else begin
                    next_cnt = cnt + CNT_ONE;
                end
            end
            S_SETTLE: begin
                if (i_osc_tick) begin
                    next_cnt = cnt + CNT_ONE;
                    if (cnt == SETTLE_LAST) begin
                        next_cnt = '0;
                        next_state = S_PIN_HOLD;
                    end
                end
            end
            S_CPU_DELAY: begin
                next_cnt = cnt + CNT_ONE;
                if (cnt == CPU_LAST) begin
                    next_cnt = '0;
                    next_state = S_PIN_HOLD;
                end
            end
            S_PIN_HOLD: begin
                // Release only once the external pin is high again
                if (i_ext_reset_n) begin
                    next_state = S_RUN;
                    next_pc_load = 1'b1;
                    next_ctrl_init = 1'b0;
                    next_data_init = 1'b0;
                end
            end
        endcase
        // Pin reset while running; cause bits stay as they were
        if (!i_ext_reset_n && state == S_RUN) begin
            if (sleeping) begin
                next_watchdog_expired_flag = 1'b1;
                next_sleep_entered_flag = 1'b0;
            end else begin
                next_watchdog_expired_flag = watchdog_expired_flag;
                next_sleep_entered_flag = sleep_entered_flag;
            end
            next_sleeping = 1'b0;
            next_pc_value = PC_RESET_VECTOR;
            next_ctrl_init = 1'b1;
            next_cnt = '0;
            next_state = S_PIN_HOLD;
            events[EV_EXT_PIN] = 1'b1;
        end
        // Brown-out outranks all; flag content is not trusted when disabled
        if (i_bor_enable && i_bor_detect) begin
            next_brownout_flag = 1'b0;
            next_watchdog_expired_flag = 1'b1;
            next_sleep_entered_flag = 1'b1;
            next_sleeping = 1'b0;
            next_pc_value = PC_RESET_VECTOR;
            next_ctrl_init = 1'b1;
            next_data_init = 1'b1;
            next_cnt = '0;
            next_state = S_TIMER;
            events[EV_BROWNOUT] = 1'b1;
        end
    end

    // Power-on is the synchronous reset itself
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= S_TIMER;
            cnt <= '0;
            brownout_flag <= BROWNOUT_POR_VALUE;
            poweron_flag <= 1'b0;
            watchdog_expired_flag <= 1'b1;
            sleep_entered_flag <= 1'b1;
            sleeping <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= PC_RESET_VECTOR;
            ctrl_init <= 1'b1;
            data_init <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            brownout_flag <= next_brownout_flag;
            poweron_flag <= next_poweron_flag;
            watchdog_expired_flag <= next_watchdog_expired_flag;
            sleep_entered_flag <= next_sleep_entered_flag;
            sleeping <= next_sleeping;
            pc_load <= next_pc_load;
            pc_value <= next_pc_value;
            ctrl_init <= next_ctrl_init;
            data_init <= next_data_init;
        end
    end

    // Interrupt status: a new event wins over a same-cycle write-one clear
    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        if (wr_fire && w_strb[0] && aw_addr == OFS_IRQ_STATUS) begin
            next_irq_status = irq_status & ~w_data[EV_W-1:0];
        end
        if (wr_fire && w_strb[0] && aw_addr == OFS_IRQ_MASK) begin
            next_irq_mask = w_data[EV_W-1:0];
        end
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_status <= IRQ_STATUS_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    // Outputs to the core
    assign o_cpu_hold = (state != S_RUN);
    assign o_pc_load = pc_load;
    assign o_pc_value = pc_value;
    assign o_ctrl_init = ctrl_init;
    assign o_data_init = data_init;
    assign o_watchdog_expired_flag = watchdog_expired_flag;
    assign o_sleep_entered_flag = sleep_entered_flag;
    assign o_irq = |(irq_status & irq_mask);

endmodule : reset_cause_status_logic

// *** reset_cause_status_logic_monitor.sv ***
// Port-level checker for reset cause flags and start-up sequencing
module reset_cause_status_logic_monitor (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_bor_enable,
    input wire logic i_bor_detect,
    input wire logic i_ext_reset_n,
    input wire logic i_watchdog_timeout,
    input wire logic o_cpu_hold,
    input wire logic o_pc_load,
    input wire logic o_ctrl_init,
    input wire logic o_data_init,
    input wire logic o_watchdog_expired_flag,
    input wire logic o_sleep_entered_flag
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    // Power-on state visible right after reset
    property p_rst_init;
        $fell(i_rst) |-> o_cpu_hold && o_ctrl_init && o_data_init
            && o_watchdog_expired_flag && o_sleep_entered_flag;
    endproperty
    a_rst_init: assert property (p_rst_init)
        else $error("power-on state wrong after reset");
    // Brown-out sets both status flags and requests full init
    property p_bor;
        i_bor_enable && i_bor_detect |=> o_cpu_hold && o_data_init
            && o_watchdog_expired_flag && o_sleep_entered_flag;
    endproperty
    a_bor: assert property (p_bor)
        else $error("brown-out state wrong");
    // Awake or asleep, watchdog clears the expired flag
    property p_wdt;
        i_watchdog_timeout && !o_cpu_hold && !i_bor_detect && i_ext_reset_n
            |=> !o_watchdog_expired_flag && o_cpu_hold;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog event state wrong");
    // A low pin keeps the core held
    property p_pin_hold;
        !i_ext_reset_n |=> o_cpu_hold;
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("core released while pin low");
    // Pin reset re-inits control registers only, data kept
    property p_pin_ctrl;
        !i_ext_reset_n && !o_cpu_hold && !(i_bor_detect && i_bor_enable)
            |=> o_ctrl_init && !o_data_init;
    endproperty
    a_pin_ctrl: assert property (p_pin_ctrl)
        else $error("pin reset init scope wrong");
    // Data init only follows power-on or brown-out
    property p_data_init;
        $rose(o_data_init) |-> $past(i_rst) || ($past(i_bor_detect) && $past(i_bor_enable));
    endproperty
    a_data_init: assert property (p_data_init)
        else $error("data init without power event");
    // Init requests drop at the release cycle
    property p_ctrl_drop;
        o_pc_load |-> !o_ctrl_init && !o_data_init;
    endproperty
    a_ctrl_drop: assert property (p_ctrl_drop)
        else $error("init still requested at release");
    // PC load marks the single cycle where hold falls
    property p_pc_release;
        o_pc_load |-> !o_cpu_hold && $past(o_cpu_hold);
    endproperty
    a_pc_release: assert property (p_pc_release)
        else $error("pc load not at release");
    // PC load is a one-cycle pulse
    property p_pc_pulse;
        o_pc_load |=> !o_pc_load;
    endproperty
    a_pc_pulse: assert property (p_pc_pulse)
        else $error("pc load longer than one cycle");

    c_bor: cover property (i_bor_enable && i_bor_detect);
    c_wdt: cover property (i_watchdog_timeout && !o_cpu_hold);
    c_release: cover property (o_pc_load);
endmodule : reset_cause_status_logic_monitor

bind reset_cause_status_logic reset_cause_status_logic_monitor u_monitor (.*);

// *** reset_cause_status_logic_tb_top.sv ***
// Self-checking bench for the reset cause and start-up sequencer
module reset_cause_status_logic_tb_top import reset_cause_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // Short start-up timer keeps power-ups brief
    localparam int STARTUP = 20;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [31:0] i_wdata = '0;
    logic [3:0] i_wstrb = 4'hF;
    logic i_bor_enable = 1'b1, i_bor_detect = 1'b0, i_ext_reset_n = 1'b1;
    logic i_watchdog_timeout = 1'b0, i_watchdog_clear = 1'b0, i_sleep_enter = 1'b0;
    logic i_irq_wake = 1'b0, i_global_irq_enable = 1'b0, i_startup_timer_disable = 1'b0;
    logic [1:0] i_osc_mode = OSC_CRYSTAL;
    logic i_osc_tick = 1'b1;
    logic [PC_W-1:0] i_pc_current = '0, o_pc_value;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cpu_hold, o_pc_load;
    logic o_ctrl_init, o_data_init, o_watchdog_expired_flag, o_sleep_entered_flag, o_irq;
    logic [1:0] o_bresp, o_rresp, rsp, exp_flags;
    logic [31:0] o_rdata, rd, d;
    logic [EV_W-1:0] exp_ev = IRQ_STATUS_RESET;
    int seed = 10896;
    int error_cnt = 0;
    int n_compared = 0;

    reset_cause_status_logic #(.STARTUP_CYCLES(STARTUP)) DUT (.*);

    // Free-running system clock
    always #4 i_sys_clk = ~i_sys_clk;

    function automatic logic [31:0] st_exp(input logic e, input logic s);
        return {27'h0, e, s, 3'h0};
    endfunction : st_exp

    // Release vector: 0 reset, 1 resume after sleep, 2 interrupt vector
    function automatic logic [PC_W-1:0] pc_exp(input int m, input logic [PC_W-1:0] cur);
        return (m == 0) ? PC_RESET_VECTOR : (m == 1) ? cur + PC_STEP : PC_IRQ_VECTOR;
    endfunction : pc_exp

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_range(input string nm, input int n, input int lo, input int hi);
        n_compared++;
        if (n < lo || n > hi) begin
            error_cnt++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, n);
        end
    endtask : chk_range

    // Write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            n++;
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        r = o_bresp;
        i_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            n++;
            if (o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        v = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask : axi_rd

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
        axi_rd(a, rd, rsp);
        chk_val(nm, e, rd);
        chk_val("rresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    endtask : rd_chk

    // One event pulse; the pin is held low for four cycles instead
    task automatic ev(input int k);
        @(posedge i_sys_clk);
        case (k)
            0: i_watchdog_timeout <= 1'b1;
            1: i_sleep_enter <= 1'b1;
            2: i_irq_wake <= 1'b1;
            3: i_bor_detect <= 1'b1;
            4: i_watchdog_clear <= 1'b1;
            default: i_ext_reset_n <= 1'b0;
        endcase
        repeat ((k == 5) ? 4 : 1) @(posedge i_sys_clk);
        {i_watchdog_timeout, i_sleep_enter, i_irq_wake, i_bor_detect, i_watchdog_clear} <= 5'h00;
        i_ext_reset_n <= 1'b1;
    endtask : ev

    // Cycles to release pulse and restart vector
    task automatic wait_rel(input logic [PC_W-1:0] pc, input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_pc_load !== 1'b1 && n < 3000);
        chk_val("pc_value", {19'h0, pc}, {19'h0, o_pc_value});
        chk_range("release_cycles", n, lo, hi);
    endtask : wait_rel

    task automatic run_case(input int k, input bit slp, input logic [31:0] st, input int m,
                            input int lo, input int hi, input int evb);
        if (slp) ev(1);
        i_pc_current <= PC_W'($random(seed));
        ev(k);
        wait_rel(pc_exp(m, i_pc_current), lo, hi);
        exp_ev[evb] = 1'b1;
        if (k == 3) exp_flags[0] = 1'b0;
        rd_chk(OFS_CPU_STATUS, st, "status");
        rd_chk(OFS_RESET_CAUSE_FLAGS, {30'h0, exp_flags}, "flags");
        rd_chk(OFS_IRQ_STATUS, {26'h0, exp_ev}, "irq_status");
    endtask : run_case

    task automatic finish_test();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    // Hang guard, far beyond the expected run
    initial begin
        repeat (30000) @(posedge i_sys_clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        wait_rel(PC_RESET_VECTOR, STARTUP + 1024, STARTUP + 1032);
        rd_chk(OFS_RESET_CAUSE_FLAGS, 32'h0, "flags_por");
        rd_chk(OFS_CPU_STATUS, st_exp(1, 1), "status_por");
        rd_chk(OFS_IRQ_STATUS, 32'h1, "irq_status_por");
        rd_chk(OFS_IRQ_MASK, 32'h0, "irq_mask_por");
        // Random flag writes; last sets both
        for (int i = 0; i < 4; i++) begin
            d = (i == 3) ? 32'hFFFF_FFFF : $random(seed);
            axi_wr(OFS_RESET_CAUSE_FLAGS, d, rsp);
            exp_flags = d[1:0];
            rd_chk(OFS_RESET_CAUSE_FLAGS, {30'h0, exp_flags}, "flags_wr");
        end
        axi_wr(OFS_CPU_STATUS, 32'h0, rsp);
        rd_chk(OFS_CPU_STATUS, st_exp(1, 1), "status_ro");
        axi_rd(8'h10, rd, rsp);
        chk_val("unmapped_rdata", 32'h0, rd);
        chk_val("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        axi_wr(8'h10, 32'hFF, rsp);
        chk_val("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        // Pending power-on event seen once unmasked
        axi_wr(OFS_IRQ_MASK, 32'h3F, rsp);
        #1 chk_val("irq_unmasked", 32'h1, {31'h0, o_irq});
        axi_wr(OFS_IRQ_STATUS, 32'h3F, rsp);
        #1 chk_val("irq_cleared", 32'h0, {31'h0, o_irq});
        exp_ev = '0;
        run_case(5, 0, st_exp(1, 1), 0, 1, 4, EV_EXT_PIN);
        run_case(0, 0, st_exp(0, 1), 0, 1, 4, EV_WDT_RESET);
        ev(4);
        rd_chk(OFS_CPU_STATUS, st_exp(1, 1), "status_clear");
        run_case(0, 1, st_exp(0, 0), 1, 1024, 1032, EV_WDT_WAKE);
        i_osc_mode <= OSC_RC;
        run_case(2, 1, st_exp(1, 0), 1, CPU_DELAY_CYCLES, CPU_DELAY_CYCLES + 8,
                 EV_IRQ_WAKE);
        i_osc_mode <= OSC_SECONDARY;
        i_global_irq_enable <= 1'b1;
        run_case(2, 1, st_exp(1, 0), 2, CPU_DELAY_CYCLES, CPU_DELAY_CYCLES + 8,
                 EV_IRQ_WAKE);
        run_case(5, 1, st_exp(1, 0), 0, 1, 4, EV_EXT_PIN);
        i_startup_timer_disable <= 1'b1;
        run_case(3, 0, st_exp(1, 1), 0, CPU_DELAY_CYCLES, CPU_DELAY_CYCLES + 8,
                 EV_BROWNOUT);
        i_osc_mode <= OSC_CRYSTAL;
        i_startup_timer_disable <= 1'b0;
        run_case(3, 0, st_exp(1, 1), 0, STARTUP + 1024, STARTUP + 1032,
                 EV_BROWNOUT);
        #1 chk_val("irq_pending", 32'h1, {31'h0, o_irq});
        axi_wr(OFS_IRQ_MASK, 32'h0, rsp);
        #1 chk_val("irq_masked", 32'h0, {31'h0, o_irq});
        finish_test();
    end
endmodule : reset_cause_status_logic_tb_top
